/* src/bih_pkg.sv */
// Purpose: constants and types of the board interrupt priority handler
// Assumes: 32-bit Avalon-MM register port, byte addresses
// Notes:   interrupt levels are numbered 1..7, 7 highest
package bih_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL     = 5'h00;
    localparam logic [4:0] OFS_ROUTE    = 5'h04;
    localparam logic [4:0] OFS_STATUS   = 5'h08;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h0c;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h10;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_BBT     = 0;
    localparam int CTRL_SF_EN   = 1;
    localparam int CTRL_SF_LVL  = 4;
    localparam int CTRL_BCL_LVL = 8;
    localparam int CTRL_VME_EN  = 16;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int ST_ABORT  = 0;
    localparam int ST_ACFAIL = 1;
    localparam int ST_SYSF   = 2;
    localparam int ST_BCLR   = 3;
    localparam int ST_LEVEL  = 4;
    localparam int ST_VECTOR = 8;

    // ------------------------------------------------------------
    // event bits, shared by irq status and irq mask
    // ------------------------------------------------------------
    localparam int EV_ABORT  = 0;
    localparam int EV_ACFAIL = 1;
    localparam int EV_SYSF   = 2;
    localparam int EV_BCLR   = 3;
    localparam int EV_VECTOR = 4;
    localparam int EV_W      = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RST_LVL     = 3'h0;
    localparam logic [6:0] RST_VME_EN  = 7'h00;
    localparam logic [7:0] RST_VECTOR  = 8'h0f;
    localparam logic [2:0] IPL_NONE_N  = 3'h7;

    // acknowledge sequencer states
    typedef enum logic [1:0] {
        ACK_IDLE,
        ACK_AUTO,
        ACK_VME,
        ACK_DONE
    } bih_ack_state_type;

endpackage : bih_pkg

/* src/bih_handler.sv */
// Purpose: prioritises 7 autovector and 7 VME-vectored levels onto the
//          processor interrupt inputs and serves interrupt acknowledge
// Assumes: all inputs synchronous to clk_sys_i; cpu_iack_i held for the
//          whole acknowledge cycle
// Notes:   registers on Avalon-MM, one wait state per access
//
// Functional notes
// - two request groups, seven autovector and seven device-vectored levels.
// - device-vectored requests are the VME interrupt lines one to seven.
// - autovector sources: board devices, abort switch, ACFAIL, SYSFAIL, BCLR.
// - highest pending level is always driven on the encoded interrupt inputs.
// - autovector outranks device-vectored within a level; 7 highest, 1 lowest.
// - on acknowledge, decode the acknowledged level and compare with requests.
// - autovector request at acked level gives VPA assertion.
// - otherwise run a VME interrupt acknowledge cycle for the vector.
// - abort and ACFAIL fixed on autovector level 7, non-maskable.
// - other autovector sources routable to levels 1..6, shared by OR.
// - each VME line maps only to its own level, never combined.
// - abort and ACFAIL states readable as status bits.
// - SYSFAIL optionally requests at selectable level; state readable.
// - BCLR requests only while block transfer bit set.
// - BCLR state always readable.
// - BCLR should be routed to an autovector level when sharing the bus.
`timescale 1ns/1ps
module bih_handler #(
    parameter int N_DEV = 4
) (
    // clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               rst_i,
    // avalon-mm register port
    input  wire logic [4:0]         avs_address_i,
    input  wire logic               avs_read_i,
    input  wire logic               avs_write_i,
    input  wire logic [31:0]        avs_writedata_i,
    output logic      [31:0]        avs_readdata_o,
    output logic                    avs_waitrequest_o,
    output logic                    irq_o,
    // request sources, active low
    input  wire logic [N_DEV-1:0]   dev_irq_n_i,
    input  wire logic               abort_n_i,
    input  wire logic               acfail_n_i,
    input  wire logic               sysfail_n_i,
    input  wire logic               bclr_n_i,
    input  wire logic [7:1]         vme_irq_n_i,
    // processor side
    output logic      [2:0]         ipl_n_o,
    input  wire logic               cpu_iack_i,
    input  wire logic [2:0]         cpu_iack_level_i,
    output logic                    vpa_n_o,
    output logic                    cpu_dtack_n_o,
    output logic      [7:0]         cpu_vector_o,
    // vme interrupt acknowledge
    output logic                    vme_iack_n_o,
    output logic                    vme_ds_n_o,
    output logic      [2:0]         vme_iack_level_o,
    input  wire logic               vme_dtack_n_i,
    input  wire logic [7:0]         vme_data_i
);

    if (N_DEV < 1 || N_DEV > 8) begin : g_chk
        $error("N_DEV must lie in 1..8");
    end

    localparam int EV_W = bih_pkg::EV_W;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic                   bbt_ff;
    logic                   sf_en_ff;
    logic [2:0]             sf_lvl_ff;
    logic [2:0]             bcl_lvl_ff;
    logic [7:1]             vme_en_ff;
    logic [3*N_DEV-1:0]     route_ff;
    logic [EV_W-1:0]        ev_stat_ff;
    logic [EV_W-1:0]        ev_mask_ff;
    logic                   ack_ff;
    logic                   acc_ok;
    logic                   wr_en;
    logic                   rd_en;
    logic [31:0]            nxt_rdata;
    logic [31:0]            ctrl_word;
    logic [31:0]            stat_word;

    assign acc_ok = ack_ff;
    assign wr_en  = avs_write_i & acc_ok;
    assign rd_en  = avs_read_i & acc_ok;
    // a single wait state keeps read data in a flop without a bypass path
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read_i | avs_write_i) & ~ack_ff;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            bbt_ff     <= 1'b0;
            sf_en_ff   <= 1'b0;
            sf_lvl_ff  <= bih_pkg::RST_LVL;
            bcl_lvl_ff <= bih_pkg::RST_LVL;
            vme_en_ff  <= bih_pkg::RST_VME_EN;
            route_ff   <= '0;
            ev_mask_ff <= '0;
        end else if (wr_en) begin
            case (avs_address_i)
                bih_pkg::OFS_CTRL: begin
                    bbt_ff     <= avs_writedata_i[bih_pkg::CTRL_BBT];
                    sf_en_ff   <= avs_writedata_i[bih_pkg::CTRL_SF_EN];
                    sf_lvl_ff  <= avs_writedata_i[bih_pkg::CTRL_SF_LVL +: 3];
                    bcl_lvl_ff <= avs_writedata_i[bih_pkg::CTRL_BCL_LVL +: 3];
                    vme_en_ff  <= avs_writedata_i[bih_pkg::CTRL_VME_EN +: 7];
                end
                bih_pkg::OFS_ROUTE: begin
                    route_ff <= avs_writedata_i[3*N_DEV-1:0];
                end
                bih_pkg::OFS_IRQ_MASK: begin
                    ev_mask_ff <= avs_writedata_i[EV_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // request routing
    // ------------------------------------------------------------
    logic [7:1]     av_req;
    logic [7:1]     autovector_request_n;
    logic [7:1]     device_vector_request_n;
    logic           bclr_req;

    assign bclr_req = bbt_ff & ~bclr_n_i;

    always_comb begin
        av_req = '0;
        // abort and acfail fixed to 7
        av_req[7] = ~abort_n_i | ~acfail_n_i;
        for (int d = 0; d < N_DEV; d++) begin
            if (route_ff[3*d +: 3] inside {[3'h1:3'h6]} && !dev_irq_n_i[d]) begin
                av_req[route_ff[3*d +: 3]] = 1'b1;
            end
        end
        if (sf_en_ff && !sysfail_n_i && sf_lvl_ff inside {[3'h1:3'h6]}) begin
            av_req[sf_lvl_ff] = 1'b1;
        end
        // bus clear lands on its chosen level
        if (bclr_req && bcl_lvl_ff inside {[3'h1:3'h6]}) begin
            av_req[bcl_lvl_ff] = 1'b1;
        end
    end

    assign autovector_request_n    = ~av_req;
    // vme lines one to one onto device-vectored levels
    // each line only reaches its own level
    assign device_vector_request_n = vme_irq_n_i | ~vme_en_ff;

    // ------------------------------------------------------------
    // priority encoder
    // ------------------------------------------------------------
    logic [2:0]     top_lvl;
    logic [2:0]     ipl_n_ff;

    // both groups share a level, order settled at acknowledge
    always_comb begin
        top_lvl = 3'h0;
        for (int l = 1; l <= 7; l++) begin
            if (!autovector_request_n[l] || !device_vector_request_n[l]) begin
                top_lvl = 3'(l);
            end
        end
    end

    // highest pending level to the processor
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ipl_n_ff <= bih_pkg::IPL_NONE_N;
        end else begin
            ipl_n_ff <= ~top_lvl;
        end
    end
    assign ipl_n_o = ipl_n_ff;

    // ------------------------------------------------------------
    // interrupt acknowledge sequencer
    // ------------------------------------------------------------
    bih_pkg::bih_ack_state_type ack_st_ff;
    logic [2:0]                 ack_lvl_ff;
    logic [7:0]                 vector_ff;
    logic                       vec_ev;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ack_st_ff  <= bih_pkg::ACK_IDLE;
            ack_lvl_ff <= bih_pkg::RST_LVL;
            vector_ff  <= bih_pkg::RST_VECTOR;
        end else begin
            case (ack_st_ff)
                bih_pkg::ACK_IDLE: begin
                    if (cpu_iack_i) begin
                        ack_lvl_ff <= cpu_iack_level_i;
                        if (cpu_iack_level_i != 3'h0 && !autovector_request_n[cpu_iack_level_i]) begin
                            ack_st_ff <= bih_pkg::ACK_AUTO;
                        end else begin
                            ack_st_ff <= bih_pkg::ACK_VME;
                        end
                    end
                end
                bih_pkg::ACK_AUTO: begin
                    if (!cpu_iack_i) begin
                        ack_st_ff <= bih_pkg::ACK_IDLE;
                    end
                end
                bih_pkg::ACK_VME: begin
                    // interrupter answers with vector and dtack
                    if (!vme_dtack_n_i) begin
                        vector_ff <= vme_data_i;
                        ack_st_ff <= bih_pkg::ACK_DONE;
                    end
                end
                bih_pkg::ACK_DONE: begin
                    if (!cpu_iack_i) begin
                        ack_st_ff <= bih_pkg::ACK_IDLE;
                    end
                end
                default: begin
                    ack_st_ff <= bih_pkg::ACK_IDLE;
                end
            endcase
        end
    end

    assign vec_ev        = (ack_st_ff == bih_pkg::ACK_VME) & ~vme_dtack_n_i;
    assign vpa_n_o       = ack_st_ff != bih_pkg::ACK_AUTO;
    assign cpu_dtack_n_o = ack_st_ff != bih_pkg::ACK_DONE;
    assign cpu_vector_o  = vector_ff;
    // level presented during the vme cycle
    assign vme_iack_n_o     = ack_st_ff != bih_pkg::ACK_VME;
    assign vme_ds_n_o       = ack_st_ff != bih_pkg::ACK_VME;
    assign vme_iack_level_o = ack_lvl_ff;

    // ------------------------------------------------------------
    // events, sticky status, interrupt output
    // ------------------------------------------------------------
    logic [3:0]         pin_q_ff;
    logic [EV_W-1:0]    ev_set;
    logic [3:0]         pin_now;

    assign pin_now = {bclr_n_i, sysfail_n_i, acfail_n_i, abort_n_i};

    // starts at the idle pin level, so reset release gives no false event
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pin_q_ff <= 4'hf;
        end else begin
            pin_q_ff <= pin_now;
        end
    end

    assign ev_set = {vec_ev, pin_q_ff & ~pin_now};

    // a read clears only the bits it returned, so an event that
    // arrives during the wait state is not lost; a new event wins
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ev_stat_ff <= '0;
        end else if (rd_en && avs_address_i == bih_pkg::OFS_IRQ_STAT) begin
            ev_stat_ff <= (ev_stat_ff & ~avs_readdata_o[EV_W-1:0]) | ev_set;
        end else begin
            ev_stat_ff <= ev_stat_ff | ev_set;
        end
    end

    assign irq_o = |(ev_stat_ff & ev_mask_ff);

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        ctrl_word = '0;
        ctrl_word[bih_pkg::CTRL_BBT]           = bbt_ff;
        ctrl_word[bih_pkg::CTRL_SF_EN]         = sf_en_ff;
        ctrl_word[bih_pkg::CTRL_SF_LVL +: 3]   = sf_lvl_ff;
        ctrl_word[bih_pkg::CTRL_BCL_LVL +: 3]  = bcl_lvl_ff;
        ctrl_word[bih_pkg::CTRL_VME_EN +: 7]   = vme_en_ff;
        stat_word = '0;
        stat_word[bih_pkg::ST_ABORT]           = ~abort_n_i;
        stat_word[bih_pkg::ST_ACFAIL]          = ~acfail_n_i;
        stat_word[bih_pkg::ST_SYSF]            = ~sysfail_n_i;
        // bclr visible regardless of block transfer bit
        stat_word[bih_pkg::ST_BCLR]            = ~bclr_n_i;
        stat_word[bih_pkg::ST_LEVEL +: 3]      = ~ipl_n_ff;
        stat_word[bih_pkg::ST_VECTOR +: 8]     = vector_ff;
    end

    always_comb begin
        case (avs_address_i)
            bih_pkg::OFS_CTRL:     nxt_rdata = ctrl_word;
            bih_pkg::OFS_ROUTE:    nxt_rdata = 32'(route_ff);
            bih_pkg::OFS_STATUS:   nxt_rdata = stat_word;
            bih_pkg::OFS_IRQ_STAT: nxt_rdata = 32'(ev_stat_ff);
            bih_pkg::OFS_IRQ_MASK: nxt_rdata = 32'(ev_mask_ff);
            default:               nxt_rdata = 32'h0000_0000;
        endcase
    end

    // data sampled in the wait cycle, stands while waitrequest is low
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack_ff) begin
            avs_readdata_o <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_abort_top_lvl: assert property (!abort_n_i |=> ipl_n_o == 3'h0)
        else $error("abort did not raise level 7");
    a_av_gives_vpa: assert property (
        ack_st_ff == bih_pkg::ACK_IDLE && cpu_iack_i && cpu_iack_level_i != 3'h0
        && !autovector_request_n[cpu_iack_level_i] |=> !vpa_n_o && vme_iack_n_o)
        else $error("autovector acknowledge did not give vpa");
    a_uv_starts_vme: assert property (
        ack_st_ff == bih_pkg::ACK_IDLE && cpu_iack_i && cpu_iack_level_i != 3'h0
        && autovector_request_n[cpu_iack_level_i] |=> !vme_iack_n_o && vpa_n_o)
        else $error("vme acknowledge not started");
    a_vme_level_out: assert property (
        $fell(vme_iack_n_o) |-> vme_iack_level_o == $past(cpu_iack_level_i))
        else $error("vme acknowledge level wrong");
    a_bclr_gated: assert property (!bbt_ff && !sf_en_ff && (&dev_irq_n_i)
        && abort_n_i && acfail_n_i && vme_en_ff == 7'h00 |=> ipl_n_o == 3'h7)
        else $error("bclr requested without block transfer bit");
    a_bclr_readable: assert property (avs_read_i && !ack_ff && avs_address_i == bih_pkg::OFS_STATUS
        |=> avs_readdata_o[bih_pkg::ST_BCLR] == !$past(bclr_n_i))
        else $error("bclr status bit wrong");
    a_uv_lowest: assert property (autovector_request_n == 7'h7f && device_vector_request_n == 7'h7e
        |=> ipl_n_o == 3'h6)
        else $error("level 1 device request not encoded");
    a_event_sticky: assert property (!abort_n_i && $past(abort_n_i) |=> ev_stat_ff[bih_pkg::EV_ABORT])
        else $error("abort event lost");
    a_vector_pass: assert property (vec_ev |=> !cpu_dtack_n_o && cpu_vector_o == $past(vme_data_i))
        else $error("vector not passed to processor");
    a_fetch_event_kept: assert property (vec_ev |=> ev_stat_ff[bih_pkg::EV_VECTOR])
        else $error("vector fetch event lost");

    c_auto_ack: cover property (!vpa_n_o ##1 vpa_n_o);
    c_vme_ack: cover property (!vme_iack_n_o ##[1:20] !cpu_dtack_n_o);
    c_irq_raised: cover property ($rose(irq_o));
    c_bclr_int: cover property (bclr_req && bcl_lvl_ff != 3'h0);
    c_slow_fetch: cover property (!vme_iack_n_o [*4] ##1 !cpu_dtack_n_o);

endmodule : bih_handler

/* tb/bih_vme_irq_model.sv */
// Purpose: bus interrupter answering the handler's acknowledge cycle
// Assumes: one interrupter per level, vector is 0xa0 plus the level
// Notes:   wait_cycles_i selects a prompt or a slow answer
`timescale 1ns/1ps
module bih_vme_irq_model (
    // clock
    input  wire logic       clk_sys_i,
    // acknowledge cycle from the handler, answer delay from the bench
    input  wire logic       vme_iack_n_i,
    input  wire logic       vme_ds_n_i,
    input  wire logic [2:0] vme_iack_level_i,
    input  wire logic [3:0] wait_cycles_i,
    // answer to the handler
    output logic            vme_dtack_n_o,
    output logic [7:0]      vme_data_o
);
    logic [3:0] wait_cnt_ff;

    initial begin
        wait_cnt_ff   = 4'h0;
        vme_dtack_n_o = 1'b1;
        vme_data_o    = 8'h5a;
    end

    always @(posedge clk_sys_i) begin
        if (!vme_iack_n_i && !vme_ds_n_i) begin
            if (wait_cnt_ff >= wait_cycles_i) begin
                vme_dtack_n_o <= 1'b0;
                vme_data_o    <= 8'ha0 | {5'h00, vme_iack_level_i};
            end else begin
                wait_cnt_ff <= wait_cnt_ff + 4'h1;
            end
        end else begin
            wait_cnt_ff   <= 4'h0;
            vme_dtack_n_o <= 1'b1;
            // released data lines toggle so a stale vector cannot pass
            vme_data_o    <= ~vme_data_o;
        end
    end
endmodule : bih_vme_irq_model

/* tb/bih_handler_bench.sv */
// Purpose: self-checking bench of the interrupt priority handler
// Assumes: register map and one wait state of the handler's register port
// Notes:   all inputs change by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module bih_handler_bench;
    logic        clk_sys_i, rst_i, avs_read_i, avs_write_i;
    logic [4:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd;
    logic        avs_waitrequest_o, irq_o, abort_n_i, acfail_n_i, sysfail_n_i, bclr_n_i;
    logic [3:0]  dev_irq_n_i, wait_cycles;
    logic [7:1]  vme_irq_n_i;
    logic [2:0]  ipl_n_o, cpu_iack_level_i, vme_iack_level_o, got_lvl;
    logic        cpu_iack_i, vpa_n_o, cpu_dtack_n_o, vme_iack_n_o, vme_ds_n_o, vme_dtack_n_i, got_vpa;
    logic [7:0]  cpu_vector_o, vme_data_i, got_vec;
    int          num_errors, check_count;
    int          cycle_cnt = 0;

    bih_handler #(.N_DEV(4)) i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
        .dev_irq_n_i(dev_irq_n_i), .abort_n_i(abort_n_i), .acfail_n_i(acfail_n_i), .sysfail_n_i(sysfail_n_i),
        .bclr_n_i(bclr_n_i), .vme_irq_n_i(vme_irq_n_i), .ipl_n_o(ipl_n_o), .cpu_iack_i(cpu_iack_i),
        .cpu_iack_level_i(cpu_iack_level_i), .vpa_n_o(vpa_n_o), .cpu_dtack_n_o(cpu_dtack_n_o),
        .cpu_vector_o(cpu_vector_o), .vme_iack_n_o(vme_iack_n_o), .vme_ds_n_o(vme_ds_n_o),
        .vme_iack_level_o(vme_iack_level_o), .vme_dtack_n_i(vme_dtack_n_i), .vme_data_i(vme_data_i));

    bih_vme_irq_model i_irq (.clk_sys_i(clk_sys_i), .vme_iack_n_i(vme_iack_n_o), .vme_ds_n_i(vme_ds_n_o),
        .vme_iack_level_i(vme_iack_level_o), .wait_cycles_i(wait_cycles), .vme_dtack_n_o(vme_dtack_n_i),
        .vme_data_o(vme_data_i));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // waitrequest and read data are taken at the rising edge, before the slave updates
    task automatic wait_answer(output logic [31:0] d);
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        d = avs_readdata_o;
    endtask : wait_answer

    task automatic bus_wr(input logic [4:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        @(posedge clk_sys_i);
        avs_address_i   <= adr;
        avs_writedata_i <= dat;
        avs_write_i     <= 1'b1;
        wait_answer(d);
        avs_write_i     <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [4:0] adr, output logic [31:0] d);
        @(posedge clk_sys_i);
        avs_address_i <= adr;
        avs_read_i    <= 1'b1;
        wait_answer(d);
        avs_read_i    <= 1'b0;
    endtask : bus_rd

    task automatic expect_level(input logic [2:0] lvl);
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check("ipl_n_o", {29'h0, ~lvl}, {29'h0, ipl_n_o});
    endtask : expect_level

    task automatic iack(input logic [2:0] lvl);
        @(posedge clk_sys_i);
        cpu_iack_i       <= 1'b1;
        cpu_iack_level_i <= lvl;
        got_lvl = 3'h0;
        do begin
            @(negedge clk_sys_i);
            if (vme_iack_n_o === 1'b0) got_lvl = vme_iack_level_o;
        end while (vpa_n_o !== 1'b0 && cpu_dtack_n_o !== 1'b0);
        got_vpa = (vpa_n_o === 1'b0);
        got_vec = cpu_vector_o;
        @(posedge clk_sys_i);
        cpu_iack_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask : iack

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 5000) begin
            num_errors++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {num_errors, check_count} = '0;
        {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, cpu_iack_i, cpu_iack_level_i} = '0;
        {abort_n_i, acfail_n_i, sysfail_n_i, bclr_n_i, dev_irq_n_i, vme_irq_n_i} = '1;
        wait_cycles = 4'h0;
        rst_i = 1'b1;
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(negedge clk_sys_i);
        check("ipl_n_o", 32'h7, {29'h0, ipl_n_o});
        check("cpu_vector_o", 32'h0f, {24'h0, cpu_vector_o});
        bus_rd(bih_pkg::OFS_STATUS, rd);
        check("status", 32'h0f00, rd);
        bus_wr(5'h14, 32'hffff_ffff);
        bus_rd(5'h14, rd);
        check("unmapped", 32'h0, rd);
        bus_wr(bih_pkg::OFS_IRQ_MASK, 32'h1f);
        bus_rd(bih_pkg::OFS_IRQ_MASK, rd);
        check("mask", 32'h1f, rd);
        // highest device-vectored line wins, lines released from the top
        bus_wr(bih_pkg::OFS_CTRL, 32'h007f_0000);
        for (int l = 7; l >= 1; l--) begin
            @(posedge clk_sys_i);
            vme_irq_n_i <= ~(7'h7f >> (7 - l));
            expect_level(3'(l));
        end
        // a line with its enable off is not folded into another level
        bus_wr(bih_pkg::OFS_CTRL, 32'h0004_0000);
        @(posedge clk_sys_i);
        vme_irq_n_i <= 7'h00;
        expect_level(3'h3);
        @(posedge clk_sys_i);
        vme_irq_n_i <= 7'h7b;
        // dev0 at 2, dev1 at 5, dev2 at 7 and dev3 at 0 are unrouted
        bus_wr(bih_pkg::OFS_ROUTE, 32'h1ea);
        bus_rd(bih_pkg::OFS_ROUTE, rd);
        check("route", 32'h1ea, rd);
        @(posedge clk_sys_i);
        dev_irq_n_i <= 4'h3;
        expect_level(3'h3);
        @(posedge clk_sys_i);
        dev_irq_n_i <= 4'h0;
        expect_level(3'h5);
        iack(3'h5);
        check("vpa at 5", 32'h1, {31'h0, got_vpa});
        @(posedge clk_sys_i);
        dev_irq_n_i <= 4'hf;
        expect_level(3'h3);
        iack(3'h3);
        check("vme level", 32'h3, {29'h0, got_lvl});
        check("vector", 32'ha3, {24'h0, got_vec});
        // autovector beats the device-vectored request of the same level
        bus_wr(bih_pkg::OFS_ROUTE, 32'h3);
        @(posedge clk_sys_i);
        dev_irq_n_i <= 4'he;
        expect_level(3'h3);
        iack(3'h3);
        check("vpa same level", 32'h1, {31'h0, got_vpa});
        @(posedge clk_sys_i);
        dev_irq_n_i <= 4'hf;
        wait_cycles <= 4'h5;
        iack(3'h3);
        check("slow vector", 32'ha3, {24'h0, got_vec});
        bus_rd(bih_pkg::OFS_IRQ_STAT, rd);
        check("fetch event", 32'h10, rd);
        @(negedge clk_sys_i);
        check("irq cleared", 32'h0, {31'h0, irq_o});
        @(posedge clk_sys_i);
        abort_n_i   <= 1'b0;
        vme_irq_n_i <= 7'h7f;
        expect_level(3'h7);
        check("irq abort", 32'h1, {31'h0, irq_o});
        iack(3'h7);
        check("vpa at 7", 32'h1, {31'h0, got_vpa});
        bus_rd(bih_pkg::OFS_IRQ_STAT, rd);
        check("abort event", 32'h1, rd);
        bus_wr(bih_pkg::OFS_IRQ_MASK, 32'h0);
        @(posedge clk_sys_i);
        acfail_n_i <= 1'b0;
        expect_level(3'h7);
        check("irq masked", 32'h0, {31'h0, irq_o});
        bus_rd(bih_pkg::OFS_STATUS, rd);
        check("status 7", 32'ha373, rd);
        bus_rd(bih_pkg::OFS_IRQ_STAT, rd);
        check("acfail event", 32'h2, rd);
        // system failure routed to level 4
        bus_wr(bih_pkg::OFS_CTRL, 32'h42);
        @(posedge clk_sys_i);
        {abort_n_i, acfail_n_i, sysfail_n_i} <= 3'b110;
        expect_level(3'h4);
        bus_rd(bih_pkg::OFS_STATUS, rd);
        check("status sysfail", 32'ha344, rd);
        // bus clear is ignored until the block transfer bit is set
        bus_wr(bih_pkg::OFS_CTRL, 32'h600);
        @(posedge clk_sys_i);
        {sysfail_n_i, bclr_n_i} <= 2'b10;
        expect_level(3'h0);
        bus_rd(bih_pkg::OFS_STATUS, rd);
        check("status bclr", 32'ha308, rd);
        bus_wr(bih_pkg::OFS_CTRL, 32'h601);
        expect_level(3'h6);
        final_report();
    end
endmodule : bih_handler_bench
